// file: logic/mocfg_bank.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Acceleration current limit is field times 0.2 A; zero disables it.
// - Lock current threshold is field plus one, times 0.4 A.
// - Offset 0x29 bit 7 enables the closed-loop stuck fault.
// - Ramp code 0 unlimited, 1 and 2 give 48 VCC/s, rest step down.
// - Dead time is field plus one, times 40 ns.
// - Sense threshold zero means align-and-go; else 0.2 A times field plus one.
// - Offset 0x2A bit 3 enables the open-loop stuck fault.
// - Offset 0x2A bit 2 selects regulator: zero 5 V, one 3.3 V.
// - Sense rate codes give 12, 24, 47 or 95 Hz.
// - Tach gating: both loops, closed only, closed plus first open; 11 reserved.
// - Tach ratio: 1/1, 2/3, 1/2 or 1/3 pulses per electrical cycle.
// - Bit 2 picks high limit 3/2 or 2; bit 3 low 3/4 or 1/2.
// - Offset 0x2B bit 1 selects analog or PWM speed input.
// - Offset 0x2B bit 0 set keeps the controller in open loop.
// - Transfer speed is n times 0.8 Hz, or n plus one times 12.8 Hz.
module mocfg_bank
	import mocfg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h10
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Two-wire register interface
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Transfer speed field kept by the start-up bank
	input wire logic [4:0] loopTransferSpeed,
	// Current limits
	output logic accelLimitEnable,
	output logic [11:0] accelCurrentLimitMa,
	output logic [11:0] lockCurrentThresholdMa,
	// Fault enables
	output logic closedLoopStuckEnable,
	output logic openLoopStuckEnable,
	// Closed-loop ramp and gate drive
	output logic rampUnlimited,
	output logic [16:0] closedLoopRampRate,
	output logic [9:0] deadTimeNs,
	// Inductive position sensing
	output logic inductivePositionSensing,
	output logic [11:0] inductiveSenseThresholdMa,
	output logic [6:0] inductiveSenseRateHz,
	// Regulator
	output logic regulatorVoltageSelect,
	// Tachometer output
	output logic tachOpenLoopEnable,
	output logic tachFirstOpenOnly,
	output logic tachClosedLoopEnable,
	output logic [1:0] tachPulses,
	output logic [1:0] tachCycles,
	// Motor constant limits, in halves and quarters of nominal
	output logic [2:0] motorConstantHighHalves,
	output logic [2:0] motorConstantLowQuarters,
	// Speed input and loop transfer
	output logic speedInputPwm,
	output logic closedLoopDisable,
	output logic [11:0] loopTransferSpeedDhz
);

	logic sclSync;
	logic sdaSync;
	logic sclPrev;
	logic sdaPrev;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	mocfg_state_t state;
	mocfg_state_t afterAck;
	logic [3:0] bitCnt;
	logic [7:0] shiftReg;
	logic [7:0] pointer;
	logic [7:0] txByte;
	logic [7:0] readData;
	logic masterAck;
	logic recvState;
	logic byteDone;
	logic addrMatch;
	logic addrHit;
	logic ptrLoad;
	logic wrStrobe;
	logic rdLoad;
	logic [7:0] regFile [REG_COUNT];

	mocfg_sync #(
		.RST_VAL(1'b1)
	) sclSyncU (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pinIn(sclIn),
		.level(sclSync)
	);

	mocfg_sync #(
		.RST_VAL(1'b1)
	) sdaSyncU (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pinIn(sdaIn),
		.level(sdaSync)
	);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= sclSync;
			sdaPrev <= sdaSync;
		end
	end

	assign sclRise = sclSync & ~sclPrev;
	assign sclFall = ~sclSync & sclPrev;
	assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
	assign stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync;

	assign recvState = (state == ST_ADDR) || (state == ST_PTR) || (state == ST_WRITE);
	assign byteDone = sclFall && recvState && (bitCnt == BYTE_BITS);
	assign addrMatch = (shiftReg[7:1] == DEV_ADDR);
	assign addrHit = byteDone && (state == ST_ADDR) && addrMatch;
	assign ptrLoad = byteDone && (state == ST_PTR);
	assign wrStrobe = byteDone && (state == ST_WRITE);
	assign rdLoad = sclFall && (((state == ST_ACK) && (afterAck == ST_READ)) ||
		((state == ST_RACK) && masterAck));

	// Byte framing; a start or stop anywhere resynchronises the engine
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			afterAck <= ST_IDLE;
			bitCnt <= 4'h0;
		end else if (startCond) begin
			state <= ST_ADDR;
			bitCnt <= 4'h0;
		end else if (stopCond) begin
			state <= ST_IDLE;
			bitCnt <= 4'h0;
		end else begin
			case (state)
				ST_ADDR, ST_PTR, ST_WRITE: begin
					if (sclRise) begin
						bitCnt <= bitCnt + 4'h1;
					end else if (byteDone) begin
						bitCnt <= 4'h0;
						if ((state == ST_ADDR) && !addrMatch) begin
							state <= ST_IDLE;
						end else begin
							state <= ST_ACK;
							if (state != ST_ADDR) begin
								afterAck <= ST_WRITE;
							end else if (shiftReg[0]) begin
								afterAck <= ST_READ;
							end else begin
								afterAck <= ST_PTR;
							end
						end
					end
				end
				ST_ACK: begin
					if (sclFall) begin
						state <= afterAck;
					end
				end
				ST_READ: begin
					if (sclRise) begin
						bitCnt <= bitCnt + 4'h1;
					end else if (sclFall && (bitCnt == BYTE_BITS)) begin
						state <= ST_RACK;
						bitCnt <= 4'h0;
					end
				end
				ST_RACK: begin
					if (sclFall) begin
						state <= masterAck ? ST_READ : ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shiftReg <= 8'h00;
		end else if (sclRise && recvState) begin
			shiftReg <= {shiftReg[6:0], sdaSync};
		end
	end

	// A high level in the acknowledge slot ends a read burst
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			masterAck <= 1'b0;
		end else if (sclRise && (state == ST_RACK)) begin
			masterAck <= ~sdaSync;
		end
	end

	// Pointer advances after every data byte so bursts walk the bank
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pointer <= 8'h00;
		end else if (ptrLoad) begin
			pointer <= shiftReg;
		end else if (wrStrobe || rdLoad) begin
			pointer <= pointer + 8'h01;
		end
	end

	always_comb begin
		readData = UNMAPPED_READ;
		if ((pointer >= REG_BASE) && (pointer < REG_BASE + 8'(REG_COUNT))) begin
			readData = regFile[2'(pointer - REG_BASE)];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			txByte <= 8'h00;
		end else if (rdLoad) begin
			txByte <= readData;
		end else if (sclFall && (state == ST_READ)) begin
			txByte <= {txByte[6:0], 1'b0};
		end
	end

	// Data changes only while the clock is low, so no false start or stop
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sdaOe <= 1'b0;
		end else if (startCond || stopCond) begin
			sdaOe <= 1'b0;
		end else if (addrHit || ptrLoad || wrStrobe) begin
			sdaOe <= 1'b1;
		end else if (rdLoad) begin
			sdaOe <= ~readData[7];
		end else if (sclFall && (state == ST_ACK)) begin
			sdaOe <= 1'b0;
		end else if (sclFall && (state == ST_READ)) begin
			sdaOe <= (bitCnt == BYTE_BITS) ? 1'b0 : ~txByte[6];
		end
	end

	// Open-drain: the pin is only ever pulled low
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

	// Writes outside the bank are acknowledged and dropped
	for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				regFile[i] <= REG_RESET[i];
			end else if (wrStrobe && (pointer == REG_BASE + 8'(i))) begin
				regFile[i] <= shiftReg;
			end
		end
	end

	logic decAccelEn;
	logic [11:0] decAccelMa;
	logic [11:0] decLockMa;
	logic decRampInf;
	logic [16:0] decRampRate;
	logic [9:0] decDeadNs;
	logic decSenseEn;
	logic [11:0] decSenseMa;
	logic [6:0] decSenseHz;
	logic decTachOpen;
	logic decTachFirst;
	logic decTachClosed;
	logic [1:0] decPulses;
	logic [1:0] decCycles;
	logic [2:0] decKtHigh;
	logic [2:0] decKtLow;
	logic [11:0] decXferDhz;
	logic [7:0] limitsReg;
	logic [7:0] rampReg;
	logic [7:0] senseReg;
	logic [7:0] speedReg;

	assign limitsReg = regFile[2'(OFS_LIMITS - REG_BASE)];
	assign rampReg = regFile[2'(OFS_RAMP - REG_BASE)];
	assign senseReg = regFile[2'(OFS_SENSE - REG_BASE)];
	assign speedReg = regFile[2'(OFS_SPEED - REG_BASE)];

	// Bit 0 of the limits register is stored for read-back only
	mocfg_decode decodeU (
		.limitsReg(limitsReg),
		.rampReg(rampReg),
		.senseReg(senseReg),
		.speedReg(speedReg),
		.xferField(loopTransferSpeed),
		.accelEn(decAccelEn),
		.accelMa(decAccelMa),
		.lockMa(decLockMa),
		.rampInf(decRampInf),
		.rampRate(decRampRate),
		.deadNs(decDeadNs),
		.senseEn(decSenseEn),
		.senseMa(decSenseMa),
		.senseHz(decSenseHz),
		.tachOpen(decTachOpen),
		.tachFirst(decTachFirst),
		.tachClosed(decTachClosed),
		.pulses(decPulses),
		.cycles(decCycles),
		.ktHigh(decKtHigh),
		.ktLow(decKtLow),
		.xferDhz(decXferDhz)
	);

	// Decoded settings are registered so downstream sees no decode glitches
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			accelLimitEnable <= 1'b0;
			accelCurrentLimitMa <= 12'h000;
			lockCurrentThresholdMa <= 12'h000;
			closedLoopStuckEnable <= 1'b0;
			openLoopStuckEnable <= 1'b0;
			rampUnlimited <= 1'b0;
			closedLoopRampRate <= 17'h00000;
			deadTimeNs <= 10'h000;
			inductivePositionSensing <= 1'b0;
			inductiveSenseThresholdMa <= 12'h000;
			inductiveSenseRateHz <= 7'h00;
			regulatorVoltageSelect <= 1'b0;
			tachOpenLoopEnable <= 1'b0;
			tachFirstOpenOnly <= 1'b0;
			tachClosedLoopEnable <= 1'b0;
			tachPulses <= 2'h0;
			tachCycles <= 2'h0;
			motorConstantHighHalves <= 3'h0;
			motorConstantLowQuarters <= 3'h0;
			speedInputPwm <= 1'b0;
			closedLoopDisable <= 1'b0;
			loopTransferSpeedDhz <= 12'h000;
		end else begin
			accelLimitEnable <= decAccelEn;
			accelCurrentLimitMa <= decAccelMa;
			lockCurrentThresholdMa <= decLockMa;
			closedLoopStuckEnable <= rampReg[CL_STUCK_BIT];
			openLoopStuckEnable <= senseReg[OL_STUCK_BIT];
			rampUnlimited <= decRampInf;
			closedLoopRampRate <= decRampRate;
			deadTimeNs <= decDeadNs;
			inductivePositionSensing <= decSenseEn;
			inductiveSenseThresholdMa <= decSenseMa;
			inductiveSenseRateHz <= decSenseHz;
			regulatorVoltageSelect <= senseReg[VREG_BIT];
			tachOpenLoopEnable <= decTachOpen;
			tachFirstOpenOnly <= decTachFirst;
			tachClosedLoopEnable <= decTachClosed;
			tachPulses <= decPulses;
			tachCycles <= decCycles;
			motorConstantHighHalves <= decKtHigh;
			motorConstantLowQuarters <= decKtLow;
			speedInputPwm <= speedReg[SPD_MODE_BIT];
			closedLoopDisable <= speedReg[CL_DIS_BIT];
			loopTransferSpeedDhz <= decXferDhz;
		end
	end

endmodule

`default_nettype wire

// file: logic/mocfg_pkg.sv
`default_nettype none

package mocfg_pkg;

	// Register map
	localparam logic [7:0] REG_BASE = 8'h28;
	localparam int REG_COUNT = 4;
	localparam logic [7:0] OFS_LIMITS = 8'h28;
	localparam logic [7:0] OFS_RAMP = 8'h29;
	localparam logic [7:0] OFS_SENSE = 8'h2a;
	localparam logic [7:0] OFS_SPEED = 8'h2b;
	localparam logic [3:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Field positions
	localparam int ACCEL_MSB = 7;
	localparam int ACCEL_LSB = 4;
	localparam int LOCK_MSB = 3;
	localparam int LOCK_LSB = 1;
	localparam int CL_STUCK_BIT = 7;
	localparam int RAMP_MSB = 6;
	localparam int RAMP_LSB = 4;
	localparam int DEAD_MSB = 3;
	localparam int DEAD_LSB = 0;
	localparam int SENSE_MSB = 7;
	localparam int SENSE_LSB = 4;
	localparam int OL_STUCK_BIT = 3;
	localparam int VREG_BIT = 2;
	localparam int RATE_MSB = 1;
	localparam int RATE_LSB = 0;
	localparam int TACH_OL_MSB = 7;
	localparam int TACH_OL_LSB = 6;
	localparam int TACH_CYC_MSB = 5;
	localparam int TACH_CYC_LSB = 4;
	localparam int KT_HIGH_BIT = 2;
	localparam int KT_LOW_BIT = 3;
	localparam int SPD_MODE_BIT = 1;
	localparam int CL_DIS_BIT = 0;
	localparam int XFER_RANGE_BIT = 4;

	// Units: mA, ns, 0.1 Hz, mVCC/s, Hz
	localparam logic [11:0] ACCEL_STEP_MA = 12'h0c8;
	localparam logic [11:0] LOCK_STEP_MA = 12'h190;
	localparam logic [9:0] DEAD_STEP_NS = 10'h028;
	localparam logic [11:0] SENSE_STEP_MA = 12'h0c8;
	localparam logic [11:0] XFER_FINE_DHZ = 12'h008;
	localparam logic [11:0] XFER_COARSE_DHZ = 12'h080;
	localparam logic [16:0] RAMP_FAST = 17'h0bb80;
	localparam logic [7:0][16:0] RAMP_TABLE = {17'h0002d, 17'h0005b, 17'h000be,
		17'h00172, 17'h00302, RAMP_FAST, RAMP_FAST, 17'h00000};
	localparam logic [3:0][6:0] SENSE_RATE_HZ = {7'h5f, 7'h2f, 7'h18, 7'h0c};

	// Tachometer loop-gating codes
	localparam logic [1:0] TACH_BOTH = 2'h0;
	localparam logic [1:0] TACH_CLOSED = 2'h1;
	localparam logic [1:0] TACH_FIRST = 2'h2;

	// Serial interface
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_PTR = 7'h04,
		ST_WRITE = 7'h08,
		ST_ACK = 7'h10,
		ST_READ = 7'h20,
		ST_RACK = 7'h40
	} mocfg_state_t;

endpackage

`default_nettype wire

// file: logic/mocfg_sync.sv
`timescale 1ns/10ps
`default_nettype none

module mocfg_sync
	import mocfg_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Pin and filtered level
	input wire logic pinIn,
	output logic level
);

	logic [2:0] stages;

	// A change is taken only once the last two stages agree
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stages <= {3{RST_VAL}};
			level <= RST_VAL;
		end else begin
			stages <= {stages[1:0], pinIn};
			if (stages[1] == stages[2]) begin
				level <= stages[2];
			end
		end
	end

endmodule

`default_nettype wire

// file: logic/mocfg_decode.sv
`timescale 1ns/10ps
`default_nettype none

module mocfg_decode
	import mocfg_pkg::*;
(
	// Register contents
	input wire logic [7:0] limitsReg,
	input wire logic [7:0] rampReg,
	input wire logic [7:0] senseReg,
	input wire logic [7:0] speedReg,
	input wire logic [4:0] xferField,
	// Decoded settings
	output logic accelEn,
	output logic [11:0] accelMa,
	output logic [11:0] lockMa,
	output logic rampInf,
	output logic [16:0] rampRate,
	output logic [9:0] deadNs,
	output logic senseEn,
	output logic [11:0] senseMa,
	output logic [6:0] senseHz,
	output logic tachOpen,
	output logic tachFirst,
	output logic tachClosed,
	output logic [1:0] pulses,
	output logic [1:0] cycles,
	output logic [2:0] ktHigh,
	output logic [2:0] ktLow,
	output logic [11:0] xferDhz
);

	logic [3:0] accelN;
	logic [2:0] lockN;
	logic [2:0] rampN;
	logic [3:0] senseN;
	logic [1:0] tachSel;
	logic [1:0] tachCyc;

	assign accelN = limitsReg[ACCEL_MSB:ACCEL_LSB];
	assign lockN = limitsReg[LOCK_MSB:LOCK_LSB];
	assign rampN = rampReg[RAMP_MSB:RAMP_LSB];
	assign senseN = senseReg[SENSE_MSB:SENSE_LSB];
	assign tachSel = speedReg[TACH_OL_MSB:TACH_OL_LSB];
	assign tachCyc = speedReg[TACH_CYC_MSB:TACH_CYC_LSB];

	assign accelEn = (accelN != 4'h0);
	assign accelMa = 12'(accelN) * ACCEL_STEP_MA;
	assign lockMa = (12'(lockN) + 12'h001) * LOCK_STEP_MA;
	assign rampInf = (rampN == 3'h0);
	assign rampRate = RAMP_TABLE[rampN];
	assign deadNs = (10'(rampReg[DEAD_MSB:DEAD_LSB]) + 10'h001) * DEAD_STEP_NS;
	assign senseEn = (senseN != 4'h0);
	assign senseMa = senseEn ? (12'(senseN) + 12'h001) * SENSE_STEP_MA : 12'h000;
	assign senseHz = SENSE_RATE_HZ[senseReg[RATE_MSB:RATE_LSB]];

	// Reserved gating code turns the tach output off in every loop
	assign tachOpen = (tachSel == TACH_BOTH);
	assign tachFirst = (tachSel == TACH_FIRST);
	assign tachClosed = (tachSel != 2'h3);

	always_comb begin
		case (tachCyc)
			2'h0: begin
				pulses = 2'h1;
				cycles = 2'h1;
			end
			2'h1: begin
				pulses = 2'h2;
				cycles = 2'h3;
			end
			2'h2: begin
				pulses = 2'h1;
				cycles = 2'h2;
			end
			default: begin
				pulses = 2'h1;
				cycles = 2'h3;
			end
		endcase
	end

	assign ktHigh = speedReg[KT_HIGH_BIT] ? 3'h4 : 3'h3;
	assign ktLow = speedReg[KT_LOW_BIT] ? 3'h2 : 3'h3;

	assign xferDhz = xferField[XFER_RANGE_BIT] ?
		(12'(xferField[3:0]) + 12'h001) * XFER_COARSE_DHZ :
		12'(xferField[3:0]) * XFER_FINE_DHZ;

endmodule

`default_nettype wire

// file: sim/mocfg_host.sv
`timescale 1ns/10ps
`default_nettype none

module mocfg_host (
	// Clock and wired data line
	input wire logic ref_clk,
	input wire logic sdaIn,
	// Host pins
	output logic sclIn,
	output logic sdaPull,
	// Received read byte
	output logic [7:0] rxData,
	output logic rxValid
);
	// Half period of the serial clock in ref_clk cycles; raise it for a slow host
	int h = 8;

	initial begin
		sclIn = 1'b1;
		sdaPull = 1'b0;
		rxData = 8'h00;
		rxValid = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Data only moves while the clock is low, so no false start or stop is seen
	task automatic bitx(input logic b, output logic s);
		tick(h / 2);
		sdaPull = !b;
		tick(h - h / 2);
		sclIn = 1'b1;
		tick(h);
		s = sdaIn;
		sclIn = 1'b0;
	endtask

	task automatic start();
		tick(h / 2);
		sdaPull = 1'b0;
		tick(h / 2);
		sclIn = 1'b1;
		tick(h);
		sdaPull = 1'b1;
		tick(h);
		sclIn = 1'b0;
	endtask

	task automatic stop();
		tick(h / 2);
		sdaPull = 1'b1;
		tick(h / 2);
		sclIn = 1'b1;
		tick(h);
		sdaPull = 1'b0;
		tick(h);
	endtask

	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], s);
		end
		bitx(1'b1, s);
		ack = !s;
	endtask

	task automatic rdByte(input logic more);
		logic [7:0] d;
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, d[i]);
		end
		bitx(!more, s);
		rxData = d;
		rxValid = 1'b1;
		tick(1);
		rxValid = 1'b0;
	endtask
endmodule

`default_nettype wire

// file: sim/mocfg_bank_sva.sv
`timescale 1ns/10ps
`default_nettype none

module mocfg_bank_sva
	import mocfg_pkg::*;
(
	// Clock, reset and pins
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [4:0] loopTransferSpeed,
	// Decoded settings
	input wire logic accelLimitEnable,
	input wire logic [11:0] accelCurrentLimitMa,
	input wire logic [11:0] lockCurrentThresholdMa,
	input wire logic rampUnlimited,
	input wire logic [16:0] closedLoopRampRate,
	input wire logic [9:0] deadTimeNs,
	input wire logic inductivePositionSensing,
	input wire logic [11:0] inductiveSenseThresholdMa,
	input wire logic [6:0] inductiveSenseRateHz,
	input wire logic tachOpenLoopEnable,
	input wire logic tachFirstOpenOnly,
	input wire logic tachClosedLoopEnable,
	input wire logic [11:0] loopTransferSpeedDhz
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// Outputs still hold reset zeros at the first edge after release
	logic live;
	logic [11:0] xferExp;
	assign xferExp = loopTransferSpeed[4] ? 12'((loopTransferSpeed[3:0] + 1) * 128) :
		12'(loopTransferSpeed[3:0] * 8);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			live <= 1'b0;
		end else begin
			live <= 1'b1;
		end
	end

	chk_sda_low_only: assert property (sdaOut == 1'b0)
		else $error("data pin driven high");
	chk_accel_limit: assert property (live |-> accelLimitEnable == (accelCurrentLimitMa != 0)
		&& accelCurrentLimitMa % 200 == 0 && accelCurrentLimitMa <= 3000)
		else $error("accel limit off grid");
	chk_lock_range: assert property (live |-> lockCurrentThresholdMa % 400 == 0
		&& lockCurrentThresholdMa inside {[400:3200]})
		else $error("lock threshold off grid");
	chk_ramp_codes: assert property (live |-> rampUnlimited == (closedLoopRampRate == 0)
		&& closedLoopRampRate inside {0, 45, 91, 190, 370, 770, 48000})
		else $error("ramp rate not a code value");
	chk_dead_range: assert property (live |-> deadTimeNs % 40 == 0 && deadTimeNs inside {[40:640]})
		else $error("dead time off grid");
	chk_sense_pair: assert property (live |->
		inductivePositionSensing == (inductiveSenseThresholdMa != 0)
		&& inductiveSenseThresholdMa % 200 == 0 && inductiveSenseThresholdMa != 200)
		else $error("sense threshold off grid");
	chk_rate_codes: assert property (live |-> inductiveSenseRateHz inside {12, 24, 47, 95})
		else $error("sense rate not a code value");
	chk_tach_gating: assert property (live && tachOpenLoopEnable |->
		tachClosedLoopEnable && !tachFirstOpenOnly)
		else $error("tach gating inconsistent");
	chk_xfer_speed: assert property ((live && $stable(loopTransferSpeed))[*3] |->
		loopTransferSpeedDhz == xferExp)
		else $error("transfer speed wrong");
	chk_update_on_ack: assert property ($past(live) && $changed(deadTimeNs) |-> $past(sdaOe))
		else $error("setting changed outside a write");
	chk_oe_scl_low: assert property ($past(live) && $changed(sdaOe) |-> !sclIn)
		else $error("data line moved with clock high");
	chk_oe_holds: assert property (live && $rose(sdaOe) |-> sdaOe[*8])
		else $error("data line pull too short");

	cover property (live && $rose(sdaOe));
	cover property (live && closedLoopRampRate == 17'd45);
	cover property (live && loopTransferSpeed[4] && !inductivePositionSensing);
endmodule

bind mocfg_bank mocfg_bank_sva mocfg_bank_sva_inst (.*);

`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench
	import mocfg_pkg::*;
;
	localparam logic [6:0] DEV = 7'h22;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] loopTransferSpeed = 5'h00;
	logic sdaOut, sdaOe, accelLimitEnable, closedLoopStuckEnable, openLoopStuckEnable;
	logic rampUnlimited, inductivePositionSensing, regulatorVoltageSelect, tachOpenLoopEnable;
	logic tachFirstOpenOnly, tachClosedLoopEnable, speedInputPwm, closedLoopDisable;
	logic [11:0] accelCurrentLimitMa, lockCurrentThresholdMa, inductiveSenseThresholdMa;
	logic [11:0] loopTransferSpeedDhz;
	logic [16:0] closedLoopRampRate;
	logic [9:0] deadTimeNs;
	logic [6:0] inductiveSenseRateHz;
	logic [1:0] tachPulses, tachCycles;
	logic [2:0] motorConstantHighHalves, motorConstantLowQuarters;
	logic sclIn, sdaPull, rxValid, sdaIn, a;
	logic [7:0] rxData;
	logic [7:0] shadow [4] = '{default: 8'h00};
	logic [7:0] expQ [$];
	int rampT [8] = '{0, 48000, 48000, 770, 370, 190, 91, 45};
	int hzT [4] = '{12, 24, 47, 95};
	logic [3:0] tachT [4] = '{4'h5, 4'hb, 4'h6, 4'h7};
	logic [31:0] seed = 32'h9a568567;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;

	// Open-drain line with pull-up
	assign sdaIn = !(sdaPull || sdaOe);

	mocfg_bank #(.DEV_ADDR(DEV)) mocfg_bank_inst (.*);
	mocfg_host mocfg_host_inst (.*);

	always #50 ref_clk = ~ref_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmpVal(input logic [16:0] got, input logic [16:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
		cmpVal({9'h000, got}, {9'h000, exp}, "read byte");
	endtask

	task automatic sendByte(input logic [7:0] b);
		mocfg_host_inst.wrByte(b, a);
		cmpVal(17'(a), 17'h1, "ack");
	endtask

	task automatic wrRegs(input logic [7:0] ptr, input logic [31:0] w, input int n);
		logic [7:0] p;
		mocfg_host_inst.start();
		sendByte({DEV, 1'b0});
		sendByte(ptr);
		for (int i = 0; i < n; i++) begin
			p = ptr + 8'(i);
			sendByte(w[31 - 8 * i -: 8]);
			if (p >= OFS_LIMITS && p <= OFS_SPEED) begin
				shadow[p[1:0]] = w[31 - 8 * i -: 8];
			end
		end
		mocfg_host_inst.stop();
	endtask

	task automatic rdRegs(input logic [7:0] ptr, input int n);
		logic [7:0] p;
		mocfg_host_inst.start();
		sendByte({DEV, 1'b0});
		sendByte(ptr);
		mocfg_host_inst.start();
		sendByte({DEV, 1'b1});
		for (int i = 0; i < n; i++) begin
			p = ptr + 8'(i);
			expQ.push_back((p >= OFS_LIMITS && p <= OFS_SPEED) ? shadow[p[1:0]] : 8'h00);
			mocfg_host_inst.rdByte(i < n - 1);
		end
		mocfg_host_inst.stop();
	endtask

	task automatic checkOut();
		logic [7:0] r0, r1, r2, r3;
		logic [4:0] x;
		r0 = shadow[0];
		r1 = shadow[1];
		r2 = shadow[2];
		r3 = shadow[3];
		x = loopTransferSpeed;
		cmpVal(17'(accelLimitEnable), 17'(r0[7:4] != 4'h0), "accEn");
		cmpVal(17'(accelCurrentLimitMa), 17'(r0[7:4] * 200), "accMa");
		cmpVal(17'(lockCurrentThresholdMa), 17'((r0[3:1] + 1) * 400), "lock");
		cmpVal(17'(closedLoopStuckEnable), 17'(r1[7]), "cls");
		cmpVal(17'(rampUnlimited), 17'(r1[6:4] == 3'h0), "inf");
		cmpVal(17'(closedLoopRampRate), 17'(rampT[r1[6:4]]), "ramp");
		cmpVal(17'(deadTimeNs), 17'((r1[3:0] + 1) * 40), "dead");
		cmpVal(17'(inductivePositionSensing), 17'(r2[7:4] != 4'h0), "ips");
		cmpVal(17'(inductiveSenseThresholdMa), 17'(r2[7:4] ? (r2[7:4] + 1) * 200 : 0), "ma");
		cmpVal(17'(openLoopStuckEnable), 17'(r2[3]), "ols");
		cmpVal(17'(regulatorVoltageSelect), 17'(r2[2]), "vreg");
		cmpVal(17'(inductiveSenseRateHz), 17'(hzT[r2[1:0]]), "hz");
		cmpVal(17'(tachOpenLoopEnable), 17'(r3[7:6] == 2'h0), "to");
		cmpVal(17'(tachClosedLoopEnable), 17'(r3[7:6] != 2'h3), "tc");
		cmpVal(17'(tachFirstOpenOnly), 17'(r3[7:6] == 2'h2), "tf");
		cmpVal(17'({tachPulses, tachCycles}), 17'(tachT[r3[5:4]]), "tp");
		cmpVal(17'(motorConstantHighHalves), 17'(r3[2] ? 4 : 3), "kh");
		cmpVal(17'(motorConstantLowQuarters), 17'(r3[3] ? 2 : 3), "kl");
		cmpVal(17'(speedInputPwm), 17'(r3[1]), "spd");
		cmpVal(17'(closedLoopDisable), 17'(r3[0]), "cld");
		cmpVal(17'(loopTransferSpeedDhz), 17'(x[4] ? (x[3:0] + 1) * 128 : x[3:0] * 8), "xf");
	endtask

	task automatic doReset();
		rstn = 1'b0;
		shadow = '{default: 8'h00};
		repeat (4) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		checkOut();
	endtask

	always @(posedge ref_clk) begin
		if (rxValid === 1'b1) begin
			cmpByte(rxData, expQ.pop_front());
		end
	end

	// Sixteen write and read rounds need about 33000 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			wrap_up();
		end
	end

	initial begin
		doReset();
		rdRegs(OFS_LIMITS, 5);
		mocfg_host_inst.start();
		mocfg_host_inst.wrByte({~DEV, 1'b0}, a);
		cmpVal(17'(a), 17'h0, "foreign ack");
		mocfg_host_inst.stop();
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			loopTransferSpeed = seed[28:24];
			if (k == 15) begin
				mocfg_host_inst.h = 12;
			end
			// Tach gating code 11 is never written, so its all-off decode is never checked
			wrRegs(OFS_LIMITS, {4'(k), seed[3:0], seed[4], 3'(k), ~4'(k), ~4'(k), seed[6:5],
				2'(k), 2'(k % 3), 2'(k), 2'(k >> 2), seed[8:7]}, 4);
			checkOut();
			rdRegs(OFS_LIMITS, 4);
		end
		wrRegs(OFS_SPEED, {8'h4e, 8'h5a, 16'h0000}, 2);
		rdRegs(OFS_SENSE, 3);
		checkOut();
		doReset();
		wrap_up();
	end
endmodule

`default_nettype wire
